// [hdl/tcs_flow_ctrl.sv]
`timescale 1ns/100ps
// transmit cell-space flag generation on the cell bus clock
module tcs_flow_ctrl #(
    parameter int DEPTH_W = 12
) (
    input wire logic clock, // core clock, 250 MHz
    input wire logic resetn, // async reset, active low
    input wire logic clockEn, // freezes room, selection and flag registers when low; synchronisers keep running
    input wire logic [DEPTH_W-1:0] freeWrites, // queue free space in bus writes, core domain
    input wire logic wideBus, // static config: 16-bit bus
    input wire logic octetMode, // static config: octet handshake
    input wire logic multiPhy, // static config: multi-PHY
    input wire logic atmMode, // static config: ATM mode, else clear channel
    input wire logic [tcs_pkg::ADDR_W-1:0] ownAddr, // static config: own address
    input wire logic txCellBusClock, // link clock
    input wire logic [tcs_pkg::ADDR_W-1:0] txAddr, // address bus, link domain
    output logic txCellSpaceFlag, // flag output value
    output logic txCellSpaceFlagOe // flag output enable
);
    logic octetRoom;
    logic cellRoom;
    logic octetRoom_ff;
    logic cellRoom_ff;
    logic linkOctet;
    logic linkCell;
    logic [3:0] cfgSync;
    logic selected_ff;
    logic nxt_flag;

    initial begin
        if (DEPTH_W < 6 || DEPTH_W > 16)
            $error("DEPTH_W out of range");
    end

    tcs_space_calc #(.DEPTH_W(DEPTH_W)) calc (
        .freeWrites(freeWrites),
        .wideBus(wideBus),
        .octetRoom(octetRoom),
        .cellRoom(cellRoom)
    );

    // registered so the crossing sees glitch-free levels
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            octetRoom_ff <= 1'b0;
            cellRoom_ff <= 1'b0;
        end else if (clockEn) begin
            octetRoom_ff <= octetRoom;
            cellRoom_ff <= cellRoom;
        end
    end

    // link domain: clock enable is static config, sampled in each domain's own flops
    tcs_level_sync #(.W(2)) roomSync (
        .clock(txCellBusClock),
        .resetn(resetn),
        .clockEn(1'b1),
        .din({octetRoom_ff, cellRoom_ff}),
        .dout({linkOctet, linkCell})
    );

    tcs_level_sync #(.W(4)) cfgSyncInst (
        .clock(txCellBusClock),
        .resetn(resetn),
        .clockEn(1'b1),
        .din({octetMode, multiPhy, atmMode, clockEn}),
        .dout(cfgSync)
    );

    // selection latches the cycle after the address matches
    always_ff @(posedge txCellBusClock or negedge resetn) begin
        if (!resetn) begin
            selected_ff <= 1'b0;
        end else if (cfgSync[0]) begin
            selected_ff <= (txAddr == ownAddr); // RULE5
        end
    end

    // cfgSync: [3] octet mode, [2] multi-PHY, [1] ATM mode, [0] clock enable
    always_comb begin
        if (cfgSync[2] || !cfgSync[3])
            nxt_flag = linkCell; // RULE3 RULE4 RULE6
        else
            nxt_flag = linkOctet; // RULE1 RULE2
    end

    always_ff @(posedge txCellBusClock or negedge resetn) begin
        if (!resetn) begin
            txCellSpaceFlag <= 1'b0;
        end else if (cfgSync[0]) begin
            txCellSpaceFlag <= nxt_flag;
        end
    end

    always_comb begin
        if (!cfgSync[1])
            txCellSpaceFlagOe = 1'b0; // RULE7
        else if (cfgSync[2])
            txCellSpaceFlagOe = selected_ff; // RULE5
        else
            txCellSpaceFlagOe = 1'b1;
    end

    cell_mode_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE3
        (cfgSync[0] && (cfgSync[2] || !cfgSync[3])) |=> txCellSpaceFlag == $past(linkCell))
        else $error("cell-mode flag mismatch");
    octet_mode_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE1
        (cfgSync[0] && !cfgSync[2] && cfgSync[3]) |=> txCellSpaceFlag == $past(linkOctet))
        else $error("octet-mode flag mismatch");
    clear_chan_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE7
        !cfgSync[1] |-> !txCellSpaceFlagOe)
        else $error("flag driven in clear channel mode");
    phy_select_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE5
        (cfgSync[0] && cfgSync[1] && cfgSync[2] && txAddr != ownAddr)
        |=> (cfgSync[2] && cfgSync[1]) |-> !txCellSpaceFlagOe)
        else $error("flag driven while unselected");
    multi_phy_cell_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE6
        (cfgSync[0] && cfgSync[2]) |=> txCellSpaceFlag == $past(linkCell))
        else $error("multi-PHY flag not cell level");
    atm_drive_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE7
        (cfgSync[1] && !cfgSync[2]) |-> txCellSpaceFlagOe)
        else $error("flag not driven in ATM mode");
    addr_select_a: assert property (@(posedge txCellBusClock) disable iff (!resetn) // RULE5
        cfgSync[0] |=> selected_ff == $past(txAddr == ownAddr))
        else $error("selection does not follow address");
endmodule : tcs_flow_ctrl

// [common/tcs_pkg.sv]
// constants for the transmit cell-space flow control block
// What this block does (RULE1 to RULE7, RULE10); RULE8 and RULE9 describe the processor
// (RULE1) octet mode: flag low when queue lacks room for four more writes.
// (RULE2) octet mode: flag high when queue can take four or more writes.
// (RULE3) cell mode: flag high when queue has room for one whole cell.
// (RULE4) cell mode: flag low when queue cannot take one whole cell.
// (RULE5) multi-PHY: output floats until cycle after address matches own address.
// (RULE6) once selected in multi-PHY, follow cell-level behaviour whatever octet setting.
// (RULE7) output driven only in ATM mode; inactive in clear-channel mode.
// (RULE8) processor asserts active-low write strobe; word latched on rising bus clock.
// (RULE9) processor pulses start mark high only with a cell's first word.
// (RULE10) whole-cell space counted in writes of the configured 8 or 16 bit width.
package tcs_pkg;
    localparam int CELL_BYTES = 53;
    localparam int OCTET_MARGIN = 4;
    localparam int CELL_WRITES_8 = CELL_BYTES;
    localparam int CELL_WRITES_16 = (CELL_BYTES + 1) / 2;
    localparam int QUEUE_CELLS = 16;
    localparam int ADDR_W = 5;
endpackage : tcs_pkg

// [hdl/tcs_level_sync.sv]
`timescale 1ns/100ps
// two-flop level synchroniser
module tcs_level_sync #(
    parameter int W = 1
) (
    input wire logic clock, // destination clock
    input wire logic resetn, // async reset, active low
    input wire logic clockEn, // freezes state when low
    input wire logic [W-1:0] din, // level from other domain
    output logic [W-1:0] dout // synchronised level
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            dout <= '0;
        end else if (clockEn) begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule : tcs_level_sync

// [hdl/tcs_space_calc.sv]
`timescale 1ns/100ps
// combinational free-space thresholds for the transmit queue
module tcs_space_calc #(
    parameter int DEPTH_W = 12
) (
    input wire logic [DEPTH_W-1:0] freeWrites, // free space in bus writes
    input wire logic wideBus, // 16-bit bus selected
    output logic octetRoom, // room for four more writes
    output logic cellRoom // room for one full cell
);
    function automatic logic atLeast(input logic [DEPTH_W-1:0] v, input int n);
        atLeast = (int'(v) >= n);
    endfunction : atLeast

    always_comb begin
        octetRoom = atLeast(freeWrites, tcs_pkg::OCTET_MARGIN); // RULE1 RULE2
        cellRoom = wideBus ? atLeast(freeWrites, tcs_pkg::CELL_WRITES_16)
                           : atLeast(freeWrites, tcs_pkg::CELL_WRITES_8); // RULE10
    end
endmodule : tcs_space_calc

// [dv/tcs_atm_proc.sv]
`timescale 1ns/100ps
// processor-side model presenting the transmit address on the link clock
module tcs_atm_proc (
    input wire logic txCellBusClock, // link clock
    input wire logic [tcs_pkg::ADDR_W-1:0] wantAddr, // address to present
    input wire logic sendCell, // start one cell of writes
    input wire logic wideBus, // 16-bit bus selected
    output logic [tcs_pkg::ADDR_W-1:0] txAddr, // address bus
    output logic txWriteStrobeN, // write strobe, active low
    output logic txCellStartMark // first word of a cell
);
    int word = 0;
    initial txAddr = 5'h1F;
    initial begin
        txWriteStrobeN = 1'b1;
        txCellStartMark = 1'b0;
    end
    // a started cell always runs to its last word
    always @(posedge txCellBusClock) begin
        if (sendCell || word != 0) begin
            txWriteStrobeN <= #1 1'b0;
            txCellStartMark <= #1 (word == 0);
            word = (word + 1 == (wideBus ? tcs_pkg::CELL_WRITES_16 : tcs_pkg::CELL_WRITES_8))
                ? 0 : word + 1;
        end else begin
            txWriteStrobeN <= #1 1'b1;
            txCellStartMark <= #1 1'b0;
        end
    end
    // changes just after the edge so the device samples a settled bus
    always @(posedge txCellBusClock) txAddr <= #1 wantAddr;
endmodule : tcs_atm_proc

// [dv/testbench.sv]
`timescale 1ns/100ps
// self-checking bench for the cell-space flag
module testbench;
    logic clock = 0, resetn = 0, linkClk = 0;
    logic wideBus = 0, octetMode = 1, multiPhy = 0, atmMode = 1, flag, flagOe;
    logic [11:0] freeWrites = 12'h000;
    logic [4:0] wantAddr = 5'h05, txAddr;
    logic [11:0] pts [6] = '{12'h003, 12'h004, 12'h01A, 12'h01B, 12'h034, 12'h035};
    int bad_count = 0, compares = 0, seed = 32'h08E3, i, c, writes = 0, marks = 0;
    logic sendCell = 0, strobeN, mark;
    initial forever #2 clock = ~clock;
    initial begin
        #1.3;
        forever #7.5 linkClk = ~linkClk;
    end
    tcs_flow_ctrl #(.DEPTH_W(12)) tcs_flow_ctrl_inst (.clock(clock), .resetn(resetn),
        .clockEn(1'b1), .freeWrites(freeWrites), .wideBus(wideBus), .octetMode(octetMode),
        .multiPhy(multiPhy), .atmMode(atmMode), .ownAddr(5'h05), .txCellBusClock(linkClk),
        .txAddr(txAddr), .txCellSpaceFlag(flag), .txCellSpaceFlagOe(flagOe));
    tcs_atm_proc tcs_atm_proc_inst (.txCellBusClock(linkClk), .wantAddr(wantAddr),
        .sendCell(sendCell), .wideBus(wideBus), .txAddr(txAddr),
        .txWriteStrobeN(strobeN), .txCellStartMark(mark));
    always @(posedge linkClk) begin
        if (strobeN === 1'b0)
            writes++;
        if (mark === 1'b1)
            marks++;
    end
    task check(input logic [11:0] seen, input logic [11:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    // settle covers both synchronisers with margin; levels only, no handshake
    task apply(input logic [11:0] fw, input logic w, o, m, a);
        int need;
        @(posedge clock) #1;
        {freeWrites, wideBus, octetMode, multiPhy, atmMode} = {fw, w, o, m, a};
        repeat (40) @(posedge clock);
        #1;
        need = (o && !m) ? 4 : (w ? 27 : 53);
        check({11'h000, flagOe}, {11'h000, a && (!m || wantAddr == 5'h05)});
        if (flagOe === 1'b1)
            check({11'h000, flag}, {11'h000, fw >= need});
    endtask : apply
    task finish_test;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #50000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clock);
        #1 resetn = 1;
        for (c = 0; c < 4; c++)
            for (i = 0; i < 6; i++)
                apply(pts[i], c[0], c[1], 1'b0, 1'b1);
        apply(12'h005, 1'b1, 1'b1, 1'b1, 1'b1);
        apply(12'h01B, 1'b1, 1'b1, 1'b1, 1'b1);
        wantAddr = 5'h06;
        apply(12'h035, 1'b0, 1'b0, 1'b1, 1'b1);
        wantAddr = 5'h05;
        apply(12'h035, 1'b0, 1'b0, 1'b1, 1'b1);
        apply(12'h035, 1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge linkClk) #1 sendCell = 1;
        @(posedge linkClk) #1 sendCell = 0;
        repeat (60) @(posedge linkClk);
        check(writes[11:0], 12'h035);
        check(marks[11:0], 12'h001);
        for (i = 0; i < 20; i++)
            apply($random(seed) & 12'h03F, i[0], i[1], i[2], 1'b1);
        finish_test();
    end
endmodule : testbench
